// ==== hw/pdo_regs.svh ====
// timing constants and bit positions for the port d/e/f override block
`ifndef PDO_REGS_SVH
`define PDO_REGS_SVH
`define PDO_CLK_PERIOD_PS 4000
`define PDO_SPIKE_WIDTH_PS 50000
// least time rounds up to whole cycles
`define PDO_SPIKE_CYCLES \
  ((`PDO_SPIKE_WIDTH_PS + `PDO_CLK_PERIOD_PS - 1) / `PDO_CLK_PERIOD_PS)
`define PDO_SPIKE_CNT_W 4
`define PDO_BIT_TDI 3
`define PDO_BIT_TDO 2
`define PDO_BIT_TMS 1
`define PDO_BIT_TCK 0
`endif

// ==== hw/pdo_pkg.sv ====
// types shared by the port override block
package pdo_pkg;
  typedef logic [7:0] pdo_byte_t;
  typedef logic [3:0] pdo_nib_t;
endpackage

// ==== hw/pdo_sync.sv ====
// two flip-flop synchroniser for one pin level
module pdo_sync (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_d,
  output logic o_q
);
  import pdo_pkg::*;
  logic meta_reg;
  logic meta_next;
  logic q_reg;
  logic q_next;

  // first stage feeds only the second
  always_comb begin
    meta_next = i_d;
    q_next = meta_reg;
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      meta_reg <= 1'b1;
      q_reg <= 1'b1;
    end else begin
      meta_reg <= meta_next;
      q_reg <= q_next;
    end
  end

  assign o_q = q_reg;
endmodule

// ==== hw/pdo_spike_filter.sv ====
// glitch filter: output follows input only after it holds steady long enough
`include "pdo_regs.svh"
module pdo_spike_filter (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_en,
  input wire logic i_d,
  output logic o_q
);
  import pdo_pkg::*;
  localparam logic [`PDO_SPIKE_CNT_W-1:0] HOLD =
    `PDO_SPIKE_CNT_W'(`PDO_SPIKE_CYCLES);
  logic [`PDO_SPIKE_CNT_W-1:0] cnt_reg;
  logic [`PDO_SPIKE_CNT_W-1:0] cnt_next;
  logic q_reg;
  logic q_next;

  // a new level must stand for HOLD cycles; shorter pulses reset the count
  always_comb begin
    cnt_next = '0;
    q_next = q_reg;
    if (!i_en) begin
      q_next = i_d;
    end else if (i_d != q_reg) begin
      cnt_next = cnt_reg + 1'b1;
      if (cnt_next >= HOLD) begin
        q_next = i_d;
        cnt_next = '0;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      cnt_reg <= '0;
      q_reg <= 1'b1;
    end else begin
      cnt_reg <= cnt_next;
      q_reg <= q_next;
    end
  end

  assign o_q = q_reg;
endmodule

// ==== hw/pdo_port_override.sv ====
// alternate-function override logic for port d, e6/e2 and f7..f4/f1..f0
// Functional notes
// - transmitter enable makes tx pin output, no pull-up, driven by tx data.
// - receiver enable makes rx pin input; pull-up is out bit and not disable.
// - two-wire enable takes data/clock pins; direction from line-out signals.
// - two-wire inputs filtered so pulses under 50 ns never pass.
// - two-wire pins are open-drain with slew limiting: pull low or release.
// - clock pin value override on two-wire or timer0 b; timer drives value.
// - enabled external irq on d0..d3 forces input enable high.
// - sync serial clock output forces d5 output; pin input feeds clock in.
// - d7, d6, d4 inputs feed timer0 count, timer1 count, timer1 capture.
// - boot fuse plus low boot pin at reset selects bootloader start.
// - irq6 forces e6 input enable; e2 input gives boot select, no override.
// - test port enable forces pull-ups on tdi, tms, tck, even across reset.
// - test port enable removes four test pins from port, input enable low.
// - test data out driven only in shift states, else released.
// - port f bits 1 and 0 get no digital overrides.
`include "pdo_regs.svh"
module pdo_port_override (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_ext_reset,
  // port register bank
  input wire pdo_pkg::pdo_byte_t i_port_d_out,
  input wire pdo_pkg::pdo_byte_t i_port_d_dir,
  input wire logic [1:0] i_port_e_out,
  input wire logic [1:0] i_port_e_dir,
  input wire pdo_pkg::pdo_byte_t i_port_f_out,
  input wire pdo_pkg::pdo_byte_t i_port_f_dir,
  input wire logic i_global_pullup_disable,
  input wire logic i_sleep_input_gate,
  // peripherals
  input wire logic i_serial_tx_enable,
  input wire logic i_serial_tx_data,
  input wire logic i_serial_rx_enable,
  input wire logic i_sync_serial_clock_oe,
  input wire logic i_sync_serial_clock,
  input wire logic i_two_wire_enable,
  input wire logic i_sda_line_out,
  input wire logic i_scl_line_out,
  input wire logic i_timer0_compare_b_en,
  input wire logic i_timer0_compare_b_out,
  input wire pdo_pkg::pdo_nib_t i_ext_irq_en,
  input wire logic i_ext_irq6_en,
  input wire logic i_boot_select_fuse,
  input wire logic i_test_port_enable,
  input wire logic i_tap_shift_instr_state,
  input wire logic i_tap_shift_data_state,
  input wire logic i_tap_data_out,
  // pins: d7..d0, e6 at bit 1 / e2 at bit 0, f7..f0
  input wire pdo_pkg::pdo_byte_t i_pin_d,
  input wire logic [1:0] i_pin_e,
  input wire pdo_pkg::pdo_byte_t i_pin_f,
  output pdo_pkg::pdo_byte_t o_pin_d,
  output pdo_pkg::pdo_byte_t o_pin_d_oe,
  output pdo_pkg::pdo_byte_t o_pin_d_pullup,
  output pdo_pkg::pdo_byte_t o_pin_d_slew_limit,
  output logic [1:0] o_pin_e,
  output logic [1:0] o_pin_e_oe,
  output logic [1:0] o_pin_e_pullup,
  output pdo_pkg::pdo_byte_t o_pin_f,
  output pdo_pkg::pdo_byte_t o_pin_f_oe,
  output pdo_pkg::pdo_byte_t o_pin_f_pullup,
  // synchronised inputs to peripherals
  output pdo_pkg::pdo_byte_t o_port_d_in,
  output logic [1:0] o_port_e_in,
  output pdo_pkg::pdo_byte_t o_port_f_in,
  output logic o_serial_rx_data,
  output logic o_sync_serial_clock_in,
  output logic o_sda_in,
  output logic o_scl_in,
  output logic o_timer0_count_in,
  output logic o_timer1_count_in,
  output logic o_timer1_capture_in,
  output pdo_pkg::pdo_nib_t o_ext_irq_in,
  output logic o_ext_irq6_in,
  output logic o_boot_select_pin,
  output logic o_boot_to_loader,
  output logic o_tap_tdi,
  output logic o_tap_tms,
  output logic o_tap_tck
);
  import pdo_pkg::*;

  // per-pin override set for d, e, f (e packed into low two bits)
  pdo_byte_t d_pu_oe, d_pu_ov, d_dd_oe, d_dd_ov, d_pv_oe, d_pv_ov;
  pdo_byte_t d_die_oe, d_die_ov;
  logic [1:0] e_die_oe, e_die_ov;
  pdo_byte_t f_pu_oe, f_pu_ov, f_dd_oe, f_dd_ov, f_pv_oe, f_pv_ov;
  pdo_byte_t f_die_oe, f_die_ov;
  pdo_byte_t d_pu, d_dir, d_val, d_die, f_pu, f_dir, f_val, f_die;
  pdo_byte_t sync_d, sync_f;
  logic [1:0] sync_e;
  logic [1:0] e_die;
  logic pu_ok;

  // all pins pass two flip-flops before any logic looks at them
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_sync
      pdo_sync u_sd (.i_clk(i_clk), .i_srst(i_srst), .i_d(i_pin_d[g]),
        .o_q(sync_d[g]));
      pdo_sync u_sf (.i_clk(i_clk), .i_srst(i_srst), .i_d(i_pin_f[g]),
        .o_q(sync_f[g]));
    end
    for (g = 0; g < 2; g++) begin : g_sync_e
      pdo_sync u_se (.i_clk(i_clk), .i_srst(i_srst), .i_d(i_pin_e[g]),
        .o_q(sync_e[g]));
    end
  endgenerate

  assign pu_ok = ~i_global_pullup_disable;

  // port d override table
  always_comb begin
    d_pu_oe = '0;
    d_pu_ov = '0;
    d_dd_oe = '0;
    d_dd_ov = '0;
    d_pv_oe = '0;
    d_pv_ov = '0;
    d_die_oe = '0;
    d_die_ov = '0;
    // d5: synchronous serial clock output
    d_dd_oe[5] = i_sync_serial_clock_oe;
    d_dd_ov[5] = 1'b1;
    d_pv_oe[5] = i_sync_serial_clock_oe;
    d_pv_ov[5] = i_sync_serial_clock;
    // d3: transmitter owns pin, pull-up off, direction bit ignored
    d_pu_oe[3] = i_serial_tx_enable;
    d_dd_oe[3] = i_serial_tx_enable;
    d_dd_ov[3] = 1'b1;
    d_pv_oe[3] = i_serial_tx_enable;
    d_pv_ov[3] = i_serial_tx_data;
    // d2: receiver forces input, pull-up still from port bit
    d_pu_oe[2] = i_serial_rx_enable;
    d_pu_ov[2] = i_port_d_out[2] & pu_ok;
    d_dd_oe[2] = i_serial_rx_enable;
    // d1/d0: two-wire takes both; pin driven low while line-out is low
    d_pu_oe[1] = i_two_wire_enable;
    d_pu_ov[1] = i_port_d_out[1] & pu_ok;
    d_dd_oe[1] = i_two_wire_enable;
    d_dd_ov[1] = ~i_sda_line_out;
    d_pv_oe[1] = i_two_wire_enable;
    d_pu_oe[0] = i_two_wire_enable;
    d_pu_ov[0] = i_port_d_out[0] & pu_ok;
    d_dd_oe[0] = i_two_wire_enable | i_timer0_compare_b_en;
    d_dd_ov[0] = i_two_wire_enable ? ~i_scl_line_out : i_port_d_dir[0];
    d_pv_oe[0] = i_two_wire_enable | i_timer0_compare_b_en;
    d_pv_ov[0] = i_two_wire_enable ? 1'b0 : i_timer0_compare_b_out;
    // external irq keeps the input path alive through sleep gating
    d_die_oe[3:0] = i_ext_irq_en;
    d_die_ov[3:0] = 4'hf;
  end

  // port f override table; bits 1 and 0 never overridden
  always_comb begin
    f_pu_oe = '0;
    f_pu_ov = '0;
    f_dd_oe = '0;
    f_dd_ov = '0;
    f_pv_oe = '0;
    f_pv_ov = '0;
    f_die_oe = '0;
    f_die_ov = '0;
    f_pu_oe[7:4] = {4{i_test_port_enable}};
    f_pu_ov[7:4] = 4'hb;
    f_dd_oe[7:4] = {4{i_test_port_enable}};
    f_dd_ov[6] = i_tap_shift_instr_state | i_tap_shift_data_state;
    f_pv_oe[6] = i_test_port_enable;
    f_pv_ov[6] = i_tap_data_out;
    f_die_oe[7:4] = {4{i_test_port_enable}};
  end

  // port e: irq6 on e6, e2 unoverridden
  always_comb begin
    e_die_oe = {i_ext_irq6_en, 1'b0};
    e_die_ov = 2'h2;
  end

  // select override or port setting per control
  always_comb begin
    d_pu = (d_pu_oe & d_pu_ov) | (~d_pu_oe & i_port_d_out & ~i_port_d_dir
      & {8{pu_ok}});
    d_dir = (d_dd_oe & d_dd_ov) | (~d_dd_oe & i_port_d_dir);
    d_val = (d_pv_oe & d_pv_ov) | (~d_pv_oe & i_port_d_out);
    d_die = (d_die_oe & d_die_ov) | (~d_die_oe & {8{~i_sleep_input_gate}});
    f_pu = (f_pu_oe & f_pu_ov) | (~f_pu_oe & i_port_f_out & ~i_port_f_dir
      & {8{pu_ok}});
    f_dir = (f_dd_oe & f_dd_ov) | (~f_dd_oe & i_port_f_dir);
    f_val = (f_pv_oe & f_pv_ov) | (~f_pv_oe & i_port_f_out);
    f_die = (f_die_oe & f_die_ov) | (~f_die_oe & {8{~i_sleep_input_gate}});
    e_die = (e_die_oe & e_die_ov) | (~e_die_oe & {2{~i_sleep_input_gate}});
  end

  // pad controls; two-wire pins also get slew limiting
  always_comb begin
    o_pin_d = d_val;
    o_pin_d_oe = d_dir;
    o_pin_d_pullup = d_pu;
    o_pin_d_slew_limit = {6'h00, {2{i_two_wire_enable}}};
    o_pin_e = i_port_e_out;
    o_pin_e_oe = i_port_e_dir;
    o_pin_e_pullup = i_port_e_out & ~i_port_e_dir & {2{pu_ok}};
    o_pin_f = f_val;
    o_pin_f_oe = f_dir;
    o_pin_f_pullup = f_pu;
  end

  // input side; only the port input bits are gated by the digital input enable
  assign o_port_d_in = sync_d & d_die;
  assign o_port_f_in = sync_f & f_die;
  assign o_port_e_in = sync_e & e_die;
  assign o_serial_rx_data = sync_d[2];
  assign o_sync_serial_clock_in = sync_d[5];
  assign o_timer0_count_in = sync_d[7];
  assign o_timer1_count_in = sync_d[6];
  assign o_timer1_capture_in = sync_d[4];
  assign o_ext_irq_in = sync_d[3:0];
  assign o_ext_irq6_in = sync_e[1];
  assign o_boot_select_pin = sync_e[0];
  // test port reads pins regardless of the (forced low) input enable
  assign o_tap_tdi = sync_f[`PDO_BIT_TDI+4];
  assign o_tap_tms = sync_f[`PDO_BIT_TMS+4];
  assign o_tap_tck = sync_f[`PDO_BIT_TCK+4];

  // two-wire inputs see only filtered levels
  pdo_spike_filter u_sda_filt (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_en(i_two_wire_enable),
    .i_d(sync_d[1]),
    .o_q(o_sda_in)
  );
  pdo_spike_filter u_scl_filt (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_en(i_two_wire_enable),
    .i_d(sync_d[0]),
    .o_q(o_scl_in)
  );

  // boot select: sample the pin while external reset is held; the final
  // sample at release decides, so a pin low at the pulse end wins whatever it did before
  logic boot_reg;
  logic boot_next;
  always_comb begin
    boot_next = boot_reg;
    if (i_ext_reset) begin
      boot_next = i_boot_select_fuse & ~sync_e[0];
    end
  end

  always_ff @(posedge i_clk) begin
    boot_reg <= boot_next;
  end

  assign o_boot_to_loader = boot_reg;
endmodule

// ==== tb/pdo_port_override_props.sv ====
// assertion checker watching the port override block's ports
module pdo_port_override_props (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_ext_reset,
  input wire pdo_pkg::pdo_byte_t i_port_d_out,
  input wire logic i_global_pullup_disable,
  input wire logic i_serial_tx_enable,
  input wire logic i_serial_tx_data,
  input wire logic i_serial_rx_enable,
  input wire logic i_two_wire_enable,
  input wire logic i_sda_line_out,
  input wire logic i_boot_select_fuse,
  input wire logic i_test_port_enable,
  input wire logic i_tap_shift_instr_state,
  input wire logic i_tap_shift_data_state,
  input wire pdo_pkg::pdo_byte_t i_pin_d,
  input wire pdo_pkg::pdo_byte_t o_pin_d,
  input wire pdo_pkg::pdo_byte_t o_pin_d_oe,
  input wire pdo_pkg::pdo_byte_t o_pin_d_pullup,
  input wire pdo_pkg::pdo_byte_t o_pin_f_oe,
  input wire pdo_pkg::pdo_byte_t o_pin_f_pullup,
  input wire logic o_sda_in,
  input wire logic o_timer1_capture_in,
  input wire logic o_boot_to_loader
);
  import pdo_pkg::*;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_srst);
  // a filtered rise needs the raw line high across a long window first
  sequence s_sda_rise;
    i_two_wire_enable && $past(i_two_wire_enable, 16) && $rose(o_sda_in);
  endsequence
  sequence s_sda_settled;
    $past(i_pin_d[1], 4) && $past(i_pin_d[1], 9) && $past(i_pin_d[1], 14);
  endsequence
  a_tx_pin_drive: assert property (
    i_serial_tx_enable |-> o_pin_d_oe[3] && !o_pin_d_pullup[3]
      && o_pin_d[3] == i_serial_tx_data) else $error("tx pin override");
  a_rx_pin_input: assert property (
    i_serial_rx_enable |-> !o_pin_d_oe[2] && o_pin_d_pullup[2]
      == (i_port_d_out[2] && !i_global_pullup_disable))
    else $error("rx pin override");
  a_twi_open_drain: assert property (
    i_two_wire_enable |-> o_pin_d_oe[1] == !i_sda_line_out && !o_pin_d[1])
    else $error("data line not open drain");
  a_sda_spike_block: assert property (
    s_sda_rise |-> s_sda_settled) else $error("short pulse passed filter");
  a_capture_delay: assert property (
    !$past(i_srst) && !$past(i_srst, 2)
      |-> o_timer1_capture_in == $past(i_pin_d[4], 2))
    else $error("capture input latency");
  a_tdo_shift_only: assert property (
    i_test_port_enable |-> o_pin_f_oe[6]
      == (i_tap_shift_instr_state || i_tap_shift_data_state))
    else $error("test output enable");
  a_test_pullups_on: assert property (
    i_test_port_enable |-> (o_pin_f_pullup & 8'hb0) == 8'hb0)
    else $error("test pin pull-ups off");
  a_boot_no_fuse: assert property (
    $past(i_ext_reset) && !$past(i_boot_select_fuse) |-> !o_boot_to_loader)
    else $error("boot without fuse");
  a_boot_flag_hold: assert property (
    !i_ext_reset && !$past(i_ext_reset) |-> $stable(o_boot_to_loader))
    else $error("boot flag moved outside reset");
endmodule

bind pdo_port_override pdo_port_override_props u_props (.*);

// ==== tb/pdo_pad_model.sv ====
// port d pad model: block driver, outside driver, pull-up and float
module pdo_pad_model (
  input wire logic i_clk,
  input wire pdo_pkg::pdo_byte_t i_dut_val,
  input wire pdo_pkg::pdo_byte_t i_dut_oe,
  input wire pdo_pkg::pdo_byte_t i_pullup,
  input wire pdo_pkg::pdo_byte_t i_ext_val,
  input wire pdo_pkg::pdo_byte_t i_ext_drv,
  output pdo_pkg::pdo_byte_t o_pad
);
  timeunit 1ns;
  timeprecision 100ps;
  import pdo_pkg::*;
  pdo_byte_t float_reg = 8'h5a;
  // an unpulled released line wanders so a stale level is never trusted
  always_ff @(posedge i_clk) begin
    float_reg <= ~float_reg;
  end
  // two drivers on one line: a low from either side wins
  always_comb begin
    for (int b = 0; b < 8; b++) begin
      if (i_ext_drv[b]) begin
        o_pad[b] = i_ext_val[b] & (~i_dut_oe[b] | i_dut_val[b]);
      end else if (i_dut_oe[b]) begin
        o_pad[b] = i_dut_val[b];
      end else begin
        o_pad[b] = i_pullup[b] | float_reg[b];
      end
    end
  end
endmodule

// ==== tb/tb_pdo_port_override.sv ====
// self-checking bench for the port override block
module tb_pdo_port_override;
  timeunit 1ns;
  timeprecision 100ps;
  import pdo_pkg::*;
  logic i_clk, i_srst, i_ext_reset, i_global_pullup_disable;
  logic i_sleep_input_gate, i_serial_tx_enable, i_serial_tx_data;
  logic i_serial_rx_enable, i_sync_serial_clock_oe, i_sync_serial_clock;
  logic i_two_wire_enable, i_sda_line_out, i_scl_line_out, i_ext_irq6_en;
  logic i_timer0_compare_b_en, i_timer0_compare_b_out, i_boot_select_fuse;
  logic i_test_port_enable, i_tap_shift_instr_state, i_tap_shift_data_state;
  logic i_tap_data_out, o_serial_rx_data, o_sync_serial_clock_in, o_sda_in;
  logic o_scl_in, o_timer0_count_in, o_timer1_count_in, o_timer1_capture_in;
  logic o_ext_irq6_in, o_boot_select_pin, o_boot_to_loader, o_tap_tdi;
  logic o_tap_tms, o_tap_tck;
  logic [1:0] i_port_e_out, i_port_e_dir, i_pin_e, o_pin_e, o_pin_e_oe;
  logic [1:0] o_pin_e_pullup, o_port_e_in;
  pdo_byte_t i_port_d_out, i_port_d_dir, i_port_f_out, i_port_f_dir, i_pin_d;
  pdo_byte_t i_pin_f, o_pin_d, o_pin_d_oe, o_pin_d_pullup, o_pin_d_slew_limit;
  pdo_byte_t o_pin_f, o_pin_f_oe, o_pin_f_pullup, o_port_d_in, o_port_f_in;
  pdo_byte_t ext_val, ext_drv;
  pdo_nib_t i_ext_irq_en, o_ext_irq_in;
  int mismatches, num_checks, cycles;

  pdo_pad_model u_pad (
    .i_clk(i_clk),
    .i_dut_val(o_pin_d),
    .i_dut_oe(o_pin_d_oe),
    .i_pullup(o_pin_d_pullup),
    .i_ext_val(ext_val),
    .i_ext_drv(ext_drv),
    .o_pad(i_pin_d)
  );
  pdo_port_override dut (.*);

  // 250 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  // hang guard, far above the roughly 130 cycles the run needs
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      test_done();
    end
  end

  task automatic chk(input string nm, input pdo_byte_t exp, pdo_byte_t got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  // transmitter takes pin d3 over, releases it afterwards
  task automatic t_tx();
    @(posedge i_clk);
    i_port_d_out <= 8'h08;
    i_serial_tx_enable <= 1'b1;
    #1;
    chk("tx", 8'h01, {o_pin_d_pullup[3], o_pin_d[3], o_pin_d_oe[3]});
    @(posedge i_clk);
    i_serial_tx_enable <= 1'b0;
    #1;
    chk("tx off", 8'h04, {o_pin_d_pullup[3], o_pin_d_oe[3]} << 1);
  endtask

  // receiver forces input; pull-up still follows the port bit
  task automatic t_rx();
    @(posedge i_clk);
    {i_port_d_dir, i_port_d_out, i_serial_rx_enable} <= {8'h04, 8'h04, 1'b1};
    #1;
    chk("rx pu", 8'h01, {o_pin_d_oe[2], o_pin_d_pullup[2]});
    @(posedge i_clk);
    i_global_pullup_disable <= 1'b1;
    #1;
    chk("rx pud", 8'h00, o_pin_d_pullup[2]);
    @(posedge i_clk);
    {i_port_d_dir, i_global_pullup_disable, i_serial_rx_enable} <= '0;
  endtask

  // two-wire: spike filter, open drain, slew, then timer 0 on d0
  task automatic t_twi();
    @(posedge i_clk);
    {i_sda_line_out, i_scl_line_out, ext_drv, ext_val} <= {2'b11, 16'h0202};
    {i_two_wire_enable, i_port_d_out} <= {1'b1, 8'h03};
    tick(20);
    ext_val <= 8'h00;
    tick(12);
    ext_val <= 8'h02;
    tick(20);
    chk("sda spike", 8'h01, o_sda_in);
    ext_val <= 8'h00;
    tick(18);
    chk("sda low", 8'h00, o_sda_in);
    chk("scl held", 8'h01, o_scl_in);
    ext_val <= 8'h02;
    tick(18);
    i_sda_line_out <= 1'b0;
    #1;
    chk("twi oe", 8'h2, o_pin_d_oe[1:0]);
    chk("twi val", 8'h0, o_pin_d[1:0]);
    chk("twi slew", 8'h3, o_pin_d_slew_limit[1:0]);
    @(posedge i_clk);
    {i_two_wire_enable, ext_drv} <= '0;
    {i_timer0_compare_b_en, i_timer0_compare_b_out} <= 2'b11;
    #1;
    chk("timer0_compare_b_out", 8'h01, o_pin_d[0]);
    @(posedge i_clk);
    i_timer0_compare_b_en <= 1'b0;
  endtask

  // timer, clock and interrupt inputs while sleep gating is on
  task automatic t_inputs();
    @(posedge i_clk);
    {i_sync_serial_clock_oe, i_sync_serial_clock} <= 2'b11;
    {i_sleep_input_gate, i_ext_irq_en} <= 5'h1f;
    {ext_drv, ext_val} <= 16'hdf95;
    #1;
    chk("xck out", 8'h03, {o_pin_d_oe[5], o_pin_d[5]});
    tick(3);
    chk("inputs", 8'hb5, {o_timer0_count_in, o_timer1_count_in,
        o_sync_serial_clock_in, o_timer1_capture_in, o_ext_irq_in});
    chk("irq die", 8'h05, o_port_d_in);
    chk("rx data", 8'h01, o_serial_rx_data);
    // drop gating and outside drivers so later input checks mean something
    @(posedge i_clk);
    {i_sleep_input_gate, i_ext_irq_en, ext_drv} <= '0;
    i_sync_serial_clock_oe <= 1'b0;
  endtask

  // test port: pull-ups through a reset, tdo enable, f1..f0 untouched
  task automatic t_test_port();
    @(posedge i_clk);
    {i_test_port_enable, i_pin_f} <= {1'b1, 8'hff};
    {i_port_f_dir, i_port_f_out} <= 16'h0302; // f outputs held still
    for (int i = 0; i < 4; i++) begin
      @(posedge i_clk);
      {i_tap_shift_instr_state, i_tap_shift_data_state} <= i[1:0];
      i_tap_data_out <= i[0];
      #1;
      chk("tdo oe", pdo_byte_t'(i != 0), o_pin_f_oe[6]);
      chk("tdo", pdo_byte_t'(i[0]), o_pin_f[6]);
    end
    @(posedge i_clk);
    i_srst <= 1'b1;
    #1;
    chk("tap pu", 8'hb0, o_pin_f_pullup & 8'hb0);
    @(posedge i_clk);
    i_srst <= 1'b0;
    tick(3);
    chk("tap din", 8'h00, o_port_f_in & 8'hf0);
    chk("tap in", 8'h07, {o_tap_tdi, o_tap_tms, o_tap_tck});
    chk("f1f0", 8'h0e, {o_pin_f_oe[1:0], o_pin_f[1:0]});
  endtask

  // boot pin sampled only under external reset; e6/e2 inputs
  task automatic t_boot();
    @(posedge i_clk);
    {i_boot_select_fuse, i_pin_e, i_ext_reset} <= 4'b1101;
    tick(4);
    i_ext_reset <= 1'b0;
    tick(1);
    chk("boot", 8'h01, o_boot_to_loader);
    {i_pin_e, i_ext_irq6_en} <= 3'b111;
    tick(3);
    chk("boot hold", 8'h01, o_boot_to_loader);
    chk("e pins", 8'h03, {o_ext_irq6_in, o_boot_select_pin});
    chk("e in", 8'h03, o_port_e_in);
    {i_boot_select_fuse, i_ext_reset} <= 2'b01;
    tick(4);
    chk("no fuse", 8'h00, o_boot_to_loader);
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // reset with the external reset also low-fused, then every scenario
  initial begin
    {i_global_pullup_disable, i_sleep_input_gate, i_serial_tx_enable,
     i_serial_tx_data, i_serial_rx_enable, i_sync_serial_clock_oe,
     i_sync_serial_clock, i_two_wire_enable, i_sda_line_out, i_scl_line_out,
     i_timer0_compare_b_en, i_timer0_compare_b_out, i_ext_irq6_en,
     i_boot_select_fuse, i_test_port_enable, i_tap_shift_instr_state,
     i_tap_shift_data_state, i_tap_data_out, i_port_e_out, i_port_e_dir,
     i_pin_e, i_port_d_out, i_port_d_dir, i_port_f_out, i_port_f_dir,
     i_pin_f, ext_val, ext_drv, i_ext_irq_en} = '0;
    {i_srst, i_ext_reset} = 2'b11;
    repeat (4) @(posedge i_clk);
    {i_srst, i_ext_reset} <= 2'b00;
    t_tx();
    t_rx();
    t_twi();
    t_inputs();
    t_test_port();
    t_boot();
    test_done();
  end
endmodule
